// [htr_measure_readout.sv]
// Measurement command handling and result readout over a two-wire slave port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Hold mode keeps SCL low through conversion, releases when result ready.
// - No-hold mode never stretches SCL during conversion.
// - Write address then hold command wakes device and starts conversion.
// - Repeated start with read address follows; device stretches until done.
// - After hold conversion, release SCL, send bytes, sleep 20 us later.
// - Ready no-hold read gets ACK, bytes, then sleep 20 us later.
// - Read address during running no-hold conversion is NACKed; master retries.
// - Two bytes for temperature, four for both, MSB first.
// - Readings delivered as 14-bit values, lower resolutions scaled up.
// - Temperature conversion within 0.37/0.45/0.60/0.91 ms by resolution.
// - Humidity plus temperature within 0.64/0.80/1.04/1.70 ms by resolution.
// - CRC-8 over humidity then temperature bytes follows every result.
// - Temperature-only CRC treats humidity bytes as zero, sends temperature only.
// - CRC polynomial 0x1D, init 0xFF, final XOR 0x00, no reflection.
// - Command codes E3, F3, E5, F5 for the four measurement kinds.
// - Acknowledge only the fixed 7-bit slave address.
module htr_measure_readout
    import htr_pkg::*;
#(
    parameter int T_CYC_T8 = CONV_T8_NS / CLK_PERIOD_NS,
    parameter int T_CYC_T10 = CONV_T10_NS / CLK_PERIOD_NS,
    parameter int T_CYC_T12 = CONV_T12_NS / CLK_PERIOD_NS,
    parameter int T_CYC_T14 = CONV_T14_NS / CLK_PERIOD_NS,
    parameter int T_CYC_HT8 = CONV_HT8_NS / CLK_PERIOD_NS,
    parameter int T_CYC_HT10 = CONV_HT10_NS / CLK_PERIOD_NS,
    parameter int T_CYC_HT12 = CONV_HT12_NS / CLK_PERIOD_NS,
    parameter int T_CYC_HT14 = CONV_HT14_NS / CLK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [htr_pkg::RES_W-1:0] res_sel,
    output logic conv_start,
    output logic conv_hum,
    input wire htr_pkg::htr_meas_t res_data,
    input wire logic res_valid,
    output logic res_ready,
    output logic awake
);
    import htr_pkg::*;

    htr_st_t st_ff;
    htr_st_t nxt_st;
    htr_meas_t buf_data;
    logic buf_valid;
    logic buf_pop;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic rdy;
    logic do_load;
    logic [7:0] rx_byte;
    logic [15:0] h16;
    logic [15:0] t16;
    logic [7:0] crc;

    function automatic logic [TMR_W-1:0] conv_cyc(input logic hum, input logic [RES_W-1:0] r);
        case ({hum, r})
            3'h0: return TMR_W'(T_CYC_T8);
            3'h1: return TMR_W'(T_CYC_T10);
            3'h2: return TMR_W'(T_CYC_T12);
            3'h3: return TMR_W'(T_CYC_T14);
            3'h4: return TMR_W'(T_CYC_HT8);
            3'h5: return TMR_W'(T_CYC_HT10);
            3'h6: return TMR_W'(T_CYC_HT12);
            default: return TMR_W'(T_CYC_HT14);
        endcase
    endfunction

    // Raw value arrives right-aligned at its resolution; shift by 2*(3-res)
    function automatic logic [15:0] scale16(input logic [DATA_W-1:0] v, input logic [RES_W-1:0] r);
        return {2'h0, v << {~r, 1'b0}};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Result buffer between converter and bus engine
    htr_buf2 #(.W($bits(htr_meas_t))) u_buf (
        .clock(clock),
        .srst(srst),
        .in_data(res_data),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Result framing
    assign h16 = st_ff.pend_hum ? scale16(buf_data.hum, st_ff.res_q) : 16'h0000;
    assign t16 = scale16(buf_data.temp, st_ff.res_q);
    assign crc = htr_crc8({h16, t16});
    assign rx_byte = {st_ff.shreg[6:0], sda_in};

    assign rise = scl_in & ~st_ff.scl_q;
    assign fall = ~scl_in & st_ff.scl_q;
    assign start_c = st_ff.scl_q & scl_in & st_ff.sda_q & ~sda_in;
    assign stop_c = st_ff.scl_q & scl_in & ~st_ff.sda_q & sda_in;
    // Result counts only once the guaranteed conversion time has run out
    assign rdy = st_ff.pend & (st_ff.conv_tmr == '0) & buf_valid;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_q = scl_in;
        nxt_st.sda_q = sda_in;
        nxt_st.conv_start = 1'b0;
        do_load = 1'b0;
        if (st_ff.conv_tmr != '0) begin
            nxt_st.conv_tmr = st_ff.conv_tmr - TMR_ONE;
        end
        if (st_ff.sleep_tmr != '0) begin
            nxt_st.sleep_tmr = st_ff.sleep_tmr - SLP_ONE;
            if (st_ff.sleep_tmr == SLP_ONE && !st_ff.pend) begin
                nxt_st.awake = 1'b0;
            end
        end
        if (stop_c) begin
            nxt_st.phase = PH_IDLE;
            nxt_st.sda_oe_n = 1'b1;
            nxt_st.scl_oe_n = 1'b1;
            if (st_ff.sent) begin
                nxt_st.sent = 1'b0;
                nxt_st.sleep_tmr = SLEEP_LOAD;
            end
        end else if (start_c && st_ff.phase != PH_STRETCH) begin
            nxt_st.phase = PH_ADDR;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe_n = 1'b1;
        end else begin
            case (st_ff.phase)
                PH_ADDR, PH_CMD: begin
                    if (rise && st_ff.bit_cnt != BYTE_BITS) begin
                        nxt_st.shreg = rx_byte;
                        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                        if (st_ff.bit_cnt == BIT_LAST && st_ff.phase == PH_ADDR) begin
                            nxt_st.ack_ok = 1'b0;
                            if (rx_byte[7:1] == SLAVE_ADDR) begin
                                if (!rx_byte[0]) begin
                                    nxt_st.ack_ok = 1'b1;
                                    nxt_st.ack_nxt = PH_CMD;
                                    nxt_st.awake = 1'b1;
                                    // A new wake must not be cut short by an old sleep count
                                    nxt_st.sleep_tmr = '0;
                                end else if (st_ff.pend && st_ff.pend_hold) begin
                                    nxt_st.ack_ok = 1'b1;
                                    nxt_st.ack_nxt = PH_STRETCH;
                                end else if (rdy) begin
                                    nxt_st.ack_ok = 1'b1;
                                    nxt_st.ack_nxt = PH_TX;
                                end
                                // Running no-hold conversion falls through to NACK
                            end
                        end else if (st_ff.bit_cnt == BIT_LAST) begin
                            nxt_st.ack_nxt = PH_WAIT;
                            nxt_st.ack_ok = 1'b0;
                            if (rx_byte == CMD_HOLD_T || rx_byte == CMD_NOHOLD_T ||
                                rx_byte == CMD_HOLD_HT || rx_byte == CMD_NOHOLD_HT) begin
                                nxt_st.ack_ok = 1'b1;
                                nxt_st.pend = 1'b1;
                                nxt_st.pend_hold = (rx_byte == CMD_HOLD_T) ||
                                    (rx_byte == CMD_HOLD_HT);
                                nxt_st.pend_hum = (rx_byte == CMD_HOLD_HT) ||
                                    (rx_byte == CMD_NOHOLD_HT);
                                nxt_st.res_q = res_sel;
                                nxt_st.conv_tmr = conv_cyc(nxt_st.pend_hum, res_sel);
                                nxt_st.conv_start = 1'b1;
                                nxt_st.conv_hum = nxt_st.pend_hum;
                                nxt_st.sleep_tmr = '0;
                            end
                        end
                    end else if (fall && st_ff.bit_cnt == BYTE_BITS) begin
                        if (st_ff.ack_ok) begin
                            nxt_st.sda_oe_n = 1'b0;
                            nxt_st.phase = PH_ACK;
                        end else begin
                            nxt_st.phase = PH_WAIT;
                        end
                    end
                end
                PH_ACK: begin
                    if (fall) begin
                        nxt_st.sda_oe_n = 1'b1;
                        nxt_st.bit_cnt = 4'h0;
                        nxt_st.shreg = 8'h00;
                        nxt_st.phase = st_ff.ack_nxt;
                        if (st_ff.ack_nxt == PH_STRETCH) begin
                            nxt_st.scl_oe_n = 1'b0;
                        end else if (st_ff.ack_nxt == PH_TX) begin
                            do_load = 1'b1;
                        end
                    end
                end
                PH_STRETCH: begin
                    if (rdy) begin
                        do_load = 1'b1;
                    end
                end
                PH_TX: begin
                    // SCL stays low one cycle past the load so SDA is set up first
                    nxt_st.scl_oe_n = 1'b1;
                    if (fall) begin
                        if (st_ff.bit_cnt == BIT_LAST) begin
                            nxt_st.sda_oe_n = 1'b1;
                            nxt_st.bit_cnt = 4'h0;
                            nxt_st.phase = PH_TX_ACK;
                        end else begin
                            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                            nxt_st.sda_oe_n =
                                st_ff.tx[st_ff.tx_idx][3'(BIT_LAST - 4'h1 - st_ff.bit_cnt)];
                        end
                    end
                end
                PH_TX_ACK: begin
                    if (rise) begin
                        nxt_st.ack_ok = ~sda_in && ((st_ff.tx_idx + IDX_ONE) < st_ff.tx_n);
                    end else if (fall) begin
                        if (st_ff.ack_ok) begin
                            nxt_st.tx_idx = st_ff.tx_idx + IDX_ONE;
                            nxt_st.sda_oe_n = st_ff.tx[st_ff.tx_idx + IDX_ONE][7];
                            nxt_st.phase = PH_TX;
                        end else begin
                            nxt_st.phase = PH_WAIT;
                            nxt_st.sent = 1'b0;
                            nxt_st.sleep_tmr = SLEEP_LOAD;
                        end
                    end
                end
                PH_IDLE, PH_WAIT: begin
                end
                default: begin
                    nxt_st.phase = PH_IDLE;
                end
            endcase
        end
        if (do_load) begin
            if (st_ff.pend_hum) begin
                nxt_st.tx = {crc, t16[7:0], t16[15:8], h16[7:0], h16[15:8]};
                nxt_st.tx_n = NB_HT;
            end else begin
                nxt_st.tx = {16'h0000, crc, t16[7:0], t16[15:8]};
                nxt_st.tx_n = NB_T;
            end
            nxt_st.tx_idx = 3'h0;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe_n = nxt_st.tx[0][7];
            nxt_st.pend = 1'b0;
            nxt_st.sent = 1'b1;
            nxt_st.phase = PH_TX;
        end
    end
    assign buf_pop = do_load;

    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.scl_oe_n <= 1'b1;
            st_ff.sda_oe_n <= 1'b1;
            st_ff.scl_q <= 1'b1;
            st_ff.sda_q <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Open-drain: only ever pulls low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = st_ff.scl_oe_n;
    assign sda_oe_n = st_ff.sda_oe_n;
    assign conv_start = st_ff.conv_start;
    assign conv_hum = st_ff.conv_hum;
    assign awake = st_ff.awake;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_stretch_release;
        (st_ff.phase == PH_STRETCH && rdy) |=> st_ff.phase == PH_TX && !scl_oe_n ##1 scl_oe_n;
    endproperty
    a_stretch_release: assert property (p_stretch_release) else $error("stretch release");

    property p_nohold_no_stretch;
        !scl_oe_n |-> st_ff.pend_hold;
    endproperty
    a_nohold_no_stretch: assert property (p_nohold_no_stretch) else $error("no-hold stretch");

    property p_hold_cmd_start;
        (st_ff.phase == PH_CMD && rise && st_ff.bit_cnt == BIT_LAST && rx_byte == CMD_HOLD_HT)
            |=> conv_start && conv_hum && st_ff.pend_hold ##1 !conv_start;
    endproperty
    a_hold_cmd_start: assert property (p_hold_cmd_start) else $error("hold cmd");

    property p_ack_then_stretch;
        (st_ff.phase == PH_ACK && fall && st_ff.ack_nxt == PH_STRETCH) |=> !scl_oe_n && sda_oe_n;
    endproperty
    a_ack_then_stretch: assert property (p_ack_then_stretch) else $error("ack stretch");

    property p_busy_nack;
        (st_ff.phase == PH_ADDR && fall && st_ff.bit_cnt == BYTE_BITS && !st_ff.ack_ok)
            |=> st_ff.phase == PH_WAIT && sda_oe_n;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("nack path");

    property p_byte_count;
        buf_pop |=> st_ff.tx_n == (st_ff.pend_hum ? NB_HT : NB_T) && st_ff.sent;
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("byte count");

    property p_crc_vector;
        conv_start |-> htr_crc8(32'h05800580) == 8'hF2;
    endproperty
    a_crc_vector: assert property (p_crc_vector) else $error("crc vector");

    property p_conv_t_time;
        (conv_start && !conv_hum) |-> st_ff.conv_tmr == conv_cyc(1'b0, st_ff.res_q);
    endproperty
    a_conv_t_time: assert property (p_conv_t_time) else $error("temp time");

    property p_conv_ht_time;
        (conv_start && conv_hum) |-> st_ff.conv_tmr == conv_cyc(1'b1, st_ff.res_q);
    endproperty
    a_conv_ht_time: assert property (p_conv_ht_time) else $error("hum time");

    property p_sleep_after;
        (st_ff.sleep_tmr == SLP_ONE && !st_ff.pend) |=> !awake;
    endproperty
    a_sleep_after: assert property (p_sleep_after) else $error("sleep late");

    property p_awake_during;
        (st_ff.sleep_tmr > SLP_ONE) |-> awake;
    endproperty
    a_awake_during: assert property (p_awake_during) else $error("sleep early");

    c_hold_done: cover property (st_ff.phase == PH_STRETCH ##1 st_ff.phase == PH_TX);
    c_busy_nack: cover property (st_ff.phase == PH_ADDR && fall && !st_ff.ack_ok
        && st_ff.bit_cnt == BYTE_BITS && st_ff.pend);
    c_five_bytes: cover property (st_ff.tx_idx == 3'h4 && st_ff.phase == PH_TX_ACK);
    c_sleep: cover property ($fell(awake));
endmodule
`default_nettype wire

// [htr_pkg.sv]
// Constants, types and checksum function for the humidity/temperature readout block
package htr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and bus identity
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [6:0] SLAVE_ADDR = 7'h54;

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement commands
    localparam logic [7:0] CMD_HOLD_T = 8'hE3;
    localparam logic [7:0] CMD_NOHOLD_T = 8'hF3;
    localparam logic [7:0] CMD_HOLD_HT = 8'hE5;
    localparam logic [7:0] CMD_NOHOLD_HT = 8'hF5;

    ////////////////////////////////////////////////////////////////////////////////
    // Checksum
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] CRC_XOROUT = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and counts
    localparam int DATA_W = 14;
    localparam int RES_W = 2;
    localparam int TMR_W = 18;
    localparam int SLP_W = 12;
    localparam logic [TMR_W-1:0] TMR_ONE = 18'h00001;
    localparam logic [SLP_W-1:0] SLP_ONE = 12'h001;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] IDX_ONE = 3'h1;
    localparam logic [2:0] NB_T = 3'h3;
    localparam logic [2:0] NB_HT = 3'h5;
    localparam logic [RES_W-1:0] RES_14 = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion and sleep times, longest figures, in ns
    localparam int CONV_T8_NS = 370000;
    localparam int CONV_T10_NS = 450000;
    localparam int CONV_T12_NS = 600000;
    localparam int CONV_T14_NS = 910000;
    localparam int CONV_HT8_NS = 640000;
    localparam int CONV_HT10_NS = 800000;
    localparam int CONV_HT12_NS = 1040000;
    localparam int CONV_HT14_NS = 1700000;
    localparam int SLEEP_DELAY_NS = 20000;
    localparam int SLEEP_CYC = SLEEP_DELAY_NS / CLK_PERIOD_NS;
    localparam logic [SLP_W-1:0] SLEEP_LOAD = SLP_W'(SLEEP_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_ACK, PH_CMD, PH_STRETCH, PH_TX, PH_TX_ACK, PH_WAIT
    } htr_phase_t;

    typedef struct packed {
        logic [DATA_W-1:0] hum;
        logic [DATA_W-1:0] temp;
    } htr_meas_t;

    typedef struct packed {
        htr_phase_t phase;
        htr_phase_t ack_nxt;
        logic scl_q;
        logic sda_q;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic ack_ok;
        logic pend;
        logic pend_hold;
        logic pend_hum;
        logic [RES_W-1:0] res_q;
        logic [TMR_W-1:0] conv_tmr;
        logic [4:0][7:0] tx;
        logic [2:0] tx_idx;
        logic [2:0] tx_n;
        logic sent;
        logic [SLP_W-1:0] sleep_tmr;
        logic awake;
        logic scl_oe_n;
        logic sda_oe_n;
        logic conv_start;
        logic conv_hum;
    } htr_st_t;

    // MSB-first CRC-8, no reflection
    function automatic logic [7:0] htr_crc8(input logic [31:0] data);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            if (c[7] ^ data[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c ^ CRC_XOROUT;
    endfunction

endpackage

// [htr_buf2.sv]
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module htr_buf2 #(
    parameter int W = 28
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] cnt;
        logic in_rdy;
        logic out_vld;
    } htr_buf_st_t;

    htr_buf_st_t st_ff;
    htr_buf_st_t nxt_st;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////////
    // Ready and valid are kept as flops so no path runs straight through
    always_comb begin
        nxt_st = st_ff;
        push = in_valid & st_ff.in_rdy;
        pop = out_ready & st_ff.out_vld;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
        nxt_st.in_rdy = (nxt_st.cnt != 2'h2);
        nxt_st.out_vld = (nxt_st.cnt != 2'h0);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign in_ready = st_ff.in_rdy;
    assign out_valid = st_ff.out_vld;
    assign out_data = st_ff.mem[st_ff.rd_ptr];
endmodule
`default_nettype wire

// [htr_i2c_master.sv]
// Two-wire bus master model for the readout block
`timescale 1ns/1ps
`default_nettype none
module htr_i2c_master #(
    parameter int H = 4
) (
    input wire logic clock,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic m_scl,
    output logic m_sda
);
    int stretch = 0;
    initial begin
        m_scl = 1'b1;
        m_sda = 1'b1;
    end
    task automatic wt();
        repeat (H) @(posedge clock);
    endtask
    ////////////////////////////////////////
    // Bounded wait on a held SCL, so a stuck stretch cannot hang the run
    task automatic bit_x(input logic b, output logic r);
        int n;
        n = 0;
        m_sda <= b;
        wt();
        m_scl <= 1'b1;
        @(posedge clock);
        while (scl_line !== 1'b1 && n < 20000) begin
            n++;
            @(posedge clock);
        end
        stretch += n;
        wt();
        r = sda_line;
        m_scl <= 1'b0;
        wt();
    endtask
    task automatic start();
        m_sda <= 1'b1;
        wt();
        m_scl <= 1'b1;
        wt();
        m_sda <= 1'b0;
        wt();
        m_scl <= 1'b0;
        wt();
    endtask
    task automatic stop();
        m_sda <= 1'b0;
        wt();
        m_scl <= 1'b1;
        wt();
        m_sda <= 1'b1;
        wt();
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, ack);
    endtask
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the measurement readout block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import htr_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic res_valid = 1'b0;
    logic [RES_W-1:0] res_sel = RES_14;
    htr_meas_t res_data = '0;
    htr_meas_t cv;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, conv_start, conv_hum, res_ready, awake;
    logic m_scl, m_sda, want_hum;
    wire scl_line = m_scl & scl_oe_n;
    wire sda_line = m_sda & sda_oe_n;
    int mismatches = 0;
    int checked = 0;
    int seed = 32'hdb50fba5;
    localparam int TC[8] = '{400, 450, 500, 550, 600, 650, 700, 750};
    logic [7:0] cmds[4] = '{CMD_HOLD_T, CMD_NOHOLD_T, CMD_HOLD_HT, CMD_NOHOLD_HT};
    always #5 clock = ~clock;
    htr_measure_readout #(.T_CYC_T8(TC[0]), .T_CYC_T10(TC[1]), .T_CYC_T12(TC[2]),
        .T_CYC_T14(TC[3]), .T_CYC_HT8(TC[4]), .T_CYC_HT10(TC[5]), .T_CYC_HT12(TC[6]),
        .T_CYC_HT14(TC[7])) dut (
        .clock, .srst, .scl_in(scl_line), .scl_out, .scl_oe_n, .sda_in(sda_line), .sda_out,
        .sda_oe_n, .res_sel, .conv_start, .conv_hum, .res_data, .res_valid, .res_ready, .awake);
    htr_i2c_master m (.clock, .scl_line, .sda_line, .m_scl, .m_sda);
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [7:0] crc(input logic [31:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h1D : 8'h00);
        return c;
    endfunction
    function automatic logic [13:0] raw(input logic [1:0] r);
        return 14'($random(seed)) & (14'h3FFF >> (2 * (3 - r)));
    endfunction
    function automatic int pct(input logic [15:0] v, input int span);
        return int'(v) * span / 16383;
    endfunction
    ////////////////////////////////////////
    // Converter stand-in: exactly one word per start, held until taken
    always @(posedge clock) begin
        if (conv_start === 1'b1) begin
            check(conv_hum, want_hum);
            cv.hum = raw(res_sel);
            cv.temp = raw(res_sel);
            res_data <= cv;
            res_valid <= 1'b1;
        end else if (res_ready === 1'b1) begin
            res_valid <= 1'b0;
        end
    end
    task automatic measure(input logic [7:0] cmd, input logic [1:0] r);
        logic ack;
        logic [7:0] d;
        logic [15:0] h16;
        logic [15:0] t16;
        logic [7:0] eb[5];
        logic [7:0] gb[5];
        int s0;
        int n;
        want_hum = cmd[2];
        res_sel <= r;
        m.start();
        m.wr({SLAVE_ADDR, 1'b0}, ack);
        check(ack, 0);
        m.wr(cmd, ack);
        check(ack, 0);
        s0 = m.stretch;
        if (cmd[4]) begin
            m.stop();
            m.start();
            m.wr({SLAVE_ADDR, 1'b1}, ack);
            check(ack, 1);
            m.stop();
            repeat (800) @(posedge clock);
        end
        m.start();
        m.wr({SLAVE_ADDR, 1'b1}, ack);
        check(ack, 0);
        h16 = cmd[2] ? {2'b00, cv.hum << (2 * (3 - r))} : 16'h0000;
        t16 = {2'b00, cv.temp << (2 * (3 - r))};
        eb = '{h16[15:8], h16[7:0], t16[15:8], t16[7:0], crc({h16, t16})};
        gb = eb;
        for (int k = (cmd[2] ? 0 : 2); k < 5; k++) begin
            m.rd(k == 4, d);
            gb[k] = d;
            check(d, eb[k]);
        end
        check(pct({gb[0], gb[1]}, 100) <= 100 && pct({gb[2], gb[3]}, 165) <= 165, 1);
        n = m.stretch - s0;
        if (cmd[4]) check(n, 0);
        else check(n > TC[{cmd[2], r}] - 250 && n <= TC[{cmd[2], r}], 1);
        m.stop();
        repeat (1900) @(negedge clock);
        check(awake, 1);
        repeat (200) @(negedge clock);
        check(awake, 0);
        @(posedge clock);
    endtask
    ////////////////////////////////////////
    initial begin
        logic ack;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        check(crc(32'h05800580), 8'hF2);
        check({scl_out, sda_out, scl_oe_n, sda_oe_n, awake}, 5'b00110);
        m.start();
        m.wr({7'h55, 1'b0}, ack);
        check(ack, 1);
        m.stop();
        // Unknown command, then a read with nothing pending
        m.start();
        m.wr({SLAVE_ADDR, 1'b0}, ack);
        m.wr(8'h3C, ack);
        check(ack, 1);
        m.start();
        m.wr({SLAVE_ADDR, 1'b1}, ack);
        check(ack, 1);
        m.stop();
        for (int i = 0; i < 12; i++) begin
            measure(cmds[i % 4], (i < 4) ? 2'(i) : 2'($random(seed)));
            $display("test %0d done", i);
        end
        summarize();
    end
    // Run needs roughly 45000 cycles
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
